// ===== next_data_pkg.sv
// constants for the pulse output next-data register logic.
// assumes a 32-bit classic wishbone bus with word-aligned registers.
package next_data_pkg;

  // bus geometry
  localparam int ADDR_W  = 18;
  localparam int DATA_W  = 32;
  localparam int SEL_W   = 4;
  localparam int IDX_W   = 16;

  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DATA_LOW  = 16'hffa5;
  localparam logic [IDX_W-1:0] IDX_DATA_HIGH = 16'hffa7;
  localparam logic [IDX_W-1:0] IDX_ENABLE    = 16'hff90;
  localparam logic [IDX_W-1:0] IDX_TRIG_SEL  = 16'hff91;
  localparam logic [IDX_W-1:0] IDX_STATE     = 16'hff92;

  // output group layout: group 0 is bits 3..0, group 1 is bits 7..4
  localparam int OUT_W      = 8;
  localparam int GROUP_W    = 4;
  localparam int GROUP0_LSB = 0;
  localparam int GROUP1_LSB = 4;

  // trigger select register fields
  localparam int TRIG_SEL_W   = 2;
  localparam int TRIG_G0_LSB  = 0;
  localparam int TRIG_G1_LSB  = 2;
  localparam int TRIG_REG_W   = 4;
  localparam int TIMER_CH     = 4;

  // state register fields
  localparam int STATE_PIN_LSB    = 0;
  localparam int STATE_SHARED_BIT = 8;

  // reset and fixed read values
  localparam logic [OUT_W-1:0]      DATA_RST    = 8'h00;
  localparam logic [OUT_W-1:0]      ENABLE_RST  = 8'h00;
  localparam logic [TRIG_REG_W-1:0] TRIG_RST    = 4'h0;
  localparam logic [OUT_W-1:0]      PIN_RST     = 8'h00;
  localparam logic [OUT_W-1:0]      BYTE_ONES   = 8'hff;
  localparam logic [GROUP_W-1:0]    NIBBLE_ONES = 4'hf;
  localparam logic [DATA_W-1:0]     UNMAPPED_RD = 32'h0000_0000;

endpackage

// ===== next_out_group.sv
// one pulse output group: copies next-output data to its pins on the
// compare match of the selected timer channel.
// assumes compare match inputs are one-cycle pulses on the same clock.
`timescale 1ns/10ps
module next_out_group #(
  parameter int WIDTH = 4,
  parameter int SEL_W = 2,
  parameter int CH_N  = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [SEL_W-1:0] trig_sel_in,
  input  wire logic [CH_N-1:0]  match_in,
  input  wire logic [WIDTH-1:0] data_in,
  input  wire logic [WIDTH-1:0] enable_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic             fire;
  logic [WIDTH-1:0] pin_nxt;

  // channel picked by the selector, 0 through 3
  assign fire = match_in[trig_sel_in];

  // disabled bits keep their pin value; only enabled bits take new data
  always_comb begin
    pin_nxt = pin_out;
    if (fire) begin
      pin_nxt = (data_in & enable_in) | (pin_out & ~enable_in);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out <= '0;
    end else begin
      pin_out <= pin_nxt;
    end
  end

endmodule

// ===== next_data_regs.sv
// next-output data registers for pulse output groups 0 and 1, with
// enable and trigger select registers, behind a classic wishbone slave.
// assumes timer compare match inputs are synchronous one-cycle pulses.
//
// Overview of operation
// - Shared trigger: low register holds all eight data bits, rw, reset 0.
// - Shared trigger: high register stores nothing, reads ones, drops writes.
// - Split triggers: low bits 7..4 hold group 1 data, bits 3..0 read one.
// - Split triggers: high bits 3..0 hold group 0 data, bits 7..4 read one.
// - A data bit reaches its pin only while its own enable bit is set.
// - Each group loads on the match of the channel its 2-bit selector names.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/10ps
module next_data_regs (
  input  wire logic                               CLK_IN,
  input  wire logic                               RST_IN,
  input  wire logic                               WB_CYC_IN,
  input  wire logic                               WB_STB_IN,
  input  wire logic                               WB_WE_IN,
  input  wire logic [next_data_pkg::ADDR_W-1:0]   WB_ADR_IN,
  input  wire logic [next_data_pkg::SEL_W-1:0]    WB_SEL_IN,
  input  wire logic [next_data_pkg::DATA_W-1:0]   WB_DAT_IN,
  output logic      [next_data_pkg::DATA_W-1:0]   WB_DAT_OUT,
  output logic                                    WB_ACK_OUT,
  input  wire logic [next_data_pkg::TIMER_CH-1:0] COMPARE_MATCH_IN,
  output logic      [next_data_pkg::OUT_W-1:0]    PULSE_PIN_OUT,
  output logic      [next_data_pkg::OUT_W-1:0]    PULSE_PIN_OE_OUT
);

  logic [next_data_pkg::OUT_W-1:0]      next_output_data_reg_a_r;
  logic [next_data_pkg::OUT_W-1:0]      next_out_enable_reg_a_r;
  logic [next_data_pkg::TRIG_REG_W-1:0] trig_sel_r;
  logic [next_data_pkg::DATA_W-1:0]     rd_nxt;
  logic [next_data_pkg::IDX_W-1:0]      idx;
  logic [next_data_pkg::TRIG_SEL_W-1:0] group0_trig_sel;
  logic [next_data_pkg::TRIG_SEL_W-1:0] group1_trig_sel;
  logic                                 req;
  logic                                 wr;
  logic                                 shared;
  logic                                 hit_low;
  logic                                 hit_high;
  logic                                 hit_enable;
  logic                                 hit_trig;
  logic                                 hit_state;

  // bus decode
  // a request is taken once; the ack masks it so each access acks once
  assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  // only byte lane 0 carries writable register bits
  assign wr  = req && WB_WE_IN && WB_SEL_IN[0];
  assign idx = WB_ADR_IN[next_data_pkg::ADDR_W-1:2];

  assign hit_low    = (idx == next_data_pkg::IDX_DATA_LOW);
  assign hit_high   = (idx == next_data_pkg::IDX_DATA_HIGH);
  assign hit_enable = (idx == next_data_pkg::IDX_ENABLE);
  assign hit_trig   = (idx == next_data_pkg::IDX_TRIG_SEL);
  assign hit_state  = (idx == next_data_pkg::IDX_STATE);

  assign group0_trig_sel =
    trig_sel_r[next_data_pkg::TRIG_G0_LSB +: next_data_pkg::TRIG_SEL_W];
  assign group1_trig_sel =
    trig_sel_r[next_data_pkg::TRIG_G1_LSB +: next_data_pkg::TRIG_SEL_W];

  assign shared = (group0_trig_sel == group1_trig_sel);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      WB_ACK_OUT <= 1'b0;
    end else begin
      WB_ACK_OUT <= req;
    end
  end

  // next-output data storage
  // the storage is one byte in both layouts; switching the layout
  // keeps the bits, only their address and read view move
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      next_output_data_reg_a_r <= next_data_pkg::DATA_RST;
    end else if (wr && hit_low) begin
      if (shared) begin
        next_output_data_reg_a_r <= WB_DAT_IN[7:0];
      end else begin
        next_output_data_reg_a_r[7:4] <= WB_DAT_IN[7:4];
      end
    end else if (wr && hit_high && !shared) begin
      // a shared-layout write here falls through and stores nothing
      next_output_data_reg_a_r[3:0] <= WB_DAT_IN[3:0];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      next_out_enable_reg_a_r <= next_data_pkg::ENABLE_RST;
    end else if (wr && hit_enable) begin
      next_out_enable_reg_a_r <= WB_DAT_IN[7:0];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      trig_sel_r <= next_data_pkg::TRIG_RST;
    end else if (wr && hit_trig) begin
      trig_sel_r <= WB_DAT_IN[next_data_pkg::TRIG_REG_W-1:0];
    end
  end

  // read data
  always_comb begin
    rd_nxt = next_data_pkg::UNMAPPED_RD;
    if (hit_low) begin
      if (shared) begin
        rd_nxt[7:0] = next_output_data_reg_a_r;
      end else begin
        rd_nxt[7:0] = {next_output_data_reg_a_r[7:4],
                       next_data_pkg::NIBBLE_ONES};
      end
    end else if (hit_high) begin
      if (shared) begin
        rd_nxt[7:0] = next_data_pkg::BYTE_ONES;
      end else begin
        rd_nxt[7:0] = {next_data_pkg::NIBBLE_ONES,
                       next_output_data_reg_a_r[3:0]};
      end
    end else if (hit_enable) begin
      rd_nxt[7:0] = next_out_enable_reg_a_r;
    end else if (hit_trig) begin
      rd_nxt[next_data_pkg::TRIG_REG_W-1:0] = trig_sel_r;
    end else if (hit_state) begin
      rd_nxt[next_data_pkg::STATE_PIN_LSB +: next_data_pkg::OUT_W] =
        PULSE_PIN_OUT;
      rd_nxt[next_data_pkg::STATE_SHARED_BIT] = shared;
    end
  end

  // read data is registered with the ack and held until the next read
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      WB_DAT_OUT <= next_data_pkg::UNMAPPED_RD;
    end else if (req && !WB_WE_IN) begin
      WB_DAT_OUT <= rd_nxt;
    end
  end

  // output groups
  next_out_group #(
    .WIDTH (next_data_pkg::GROUP_W),
    .SEL_W (next_data_pkg::TRIG_SEL_W),
    .CH_N  (next_data_pkg::TIMER_CH)
  ) u_group0 (
    .clk_in      (CLK_IN),
    .rst_in      (RST_IN),
    .trig_sel_in (group0_trig_sel),
    .match_in    (COMPARE_MATCH_IN),
    .data_in     (next_output_data_reg_a_r[3:0]),
    .enable_in   (next_out_enable_reg_a_r[3:0]),
    .pin_out     (PULSE_PIN_OUT[3:0])
  );

  next_out_group #(
    .WIDTH (next_data_pkg::GROUP_W),
    .SEL_W (next_data_pkg::TRIG_SEL_W),
    .CH_N  (next_data_pkg::TIMER_CH)
  ) u_group1 (
    .clk_in      (CLK_IN),
    .rst_in      (RST_IN),
    .trig_sel_in (group1_trig_sel),
    .match_in    (COMPARE_MATCH_IN),
    .data_in     (next_output_data_reg_a_r[7:4]),
    .enable_in   (next_out_enable_reg_a_r[7:4]),
    .pin_out     (PULSE_PIN_OUT[7:4])
  );

  // a pin is driven by this unit only while its enable is set
  assign PULSE_PIN_OE_OUT = next_out_enable_reg_a_r;

  // checks
  // reads are judged one cycle after they are taken, when the ack and
  // the registered read data stand together
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  chk_shared_low_write: assert property (
    (wr && hit_low && shared) |=>
      next_output_data_reg_a_r == $past(WB_DAT_IN[7:0]))
    else $error("shared low write not stored in full");

  chk_shared_high_ones: assert property (
    (req && !WB_WE_IN && hit_high && shared) |=>
      WB_ACK_OUT && WB_DAT_OUT[7:0] == 8'hff)
    else $error("shared high read not all ones");

  chk_shared_high_nostore: assert property (
    (wr && hit_high && shared) |=> $stable(next_output_data_reg_a_r))
    else $error("shared high write changed data");

  chk_split_low_view: assert property (
    (req && !WB_WE_IN && hit_low && !shared) |=>
      WB_DAT_OUT[3:0] == 4'hf &&
      WB_DAT_OUT[7:4] == $past(next_output_data_reg_a_r[7:4]))
    else $error("split low read view wrong");

  chk_split_low_write: assert property (
    (wr && hit_low && !shared) |=>
      next_output_data_reg_a_r[3:0] ==
        $past(next_output_data_reg_a_r[3:0]) &&
      next_output_data_reg_a_r[7:4] == $past(WB_DAT_IN[7:4]))
    else $error("split low write touched group 0");

  chk_split_high_write: assert property (
    (wr && hit_high && !shared) |=>
      next_output_data_reg_a_r[3:0] == $past(WB_DAT_IN[3:0]) &&
      next_output_data_reg_a_r[7:4] ==
        $past(next_output_data_reg_a_r[7:4]))
    else $error("split high write not stored in group 0 bits");

  chk_disabled_holds: assert property (
    !next_out_enable_reg_a_r[0] |=> $stable(PULSE_PIN_OUT[0]))
    else $error("disabled pin changed");

  chk_group1_fire: assert property (
    (COMPARE_MATCH_IN[group1_trig_sel] &&
     next_out_enable_reg_a_r[7:4] == 4'hf) |=>
      PULSE_PIN_OUT[7:4] == $past(next_output_data_reg_a_r[7:4]))
    else $error("group 1 not loaded on its match");

  chk_no_fire_holds: assert property (
    !COMPARE_MATCH_IN[group0_trig_sel] |=> $stable(PULSE_PIN_OUT[3:0]))
    else $error("group 0 changed without its match");

  chk_shared_flag: assert property (
    (req && !WB_WE_IN && hit_state) |=>
      WB_DAT_OUT[8] == ($past(group0_trig_sel) == $past(group1_trig_sel)))
    else $error("shared flag disagrees with selectors");

  chk_ack_single: assert property (
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held longer than one cycle");

  chk_ack_follows: assert property (
    req |=> WB_ACK_OUT)
    else $error("request not acked in the next cycle");

  chk_shared_low_read: assert property (
    (req && !WB_WE_IN && hit_low && shared) |=>
      WB_DAT_OUT == {24'h0, $past(next_output_data_reg_a_r)})
    else $error("shared low read view wrong");

  chk_lane_gate: assert property (
    (req && WB_WE_IN && !WB_SEL_IN[0]) |=>
      $stable(next_output_data_reg_a_r) &&
      $stable(next_out_enable_reg_a_r) && $stable(trig_sel_r))
    else $error("write without byte lane 0 changed a register");

  chk_split_high_view: assert property (
    (req && !WB_WE_IN && hit_high && !shared) |=>
      WB_DAT_OUT == {24'h0, 4'hf, $past(next_output_data_reg_a_r[3:0])})
    else $error("split high read view wrong");

  chk_enable_write: assert property (
    (wr && hit_enable) |=> PULSE_PIN_OE_OUT == $past(WB_DAT_IN[7:0]))
    else $error("enable write not seen on pin enables");

  chk_enable_read: assert property (
    (req && !WB_WE_IN && hit_enable) |=>
      WB_DAT_OUT == {24'h0, $past(next_out_enable_reg_a_r)})
    else $error("enable read wrong");

  chk_disabled_top_holds: assert property (
    !next_out_enable_reg_a_r[7] |=> $stable(PULSE_PIN_OUT[7]))
    else $error("disabled top pin changed");

  chk_group0_fire: assert property (
    (COMPARE_MATCH_IN[group0_trig_sel] &&
     next_out_enable_reg_a_r[3:0] == 4'hf) |=>
      PULSE_PIN_OUT[3:0] == $past(next_output_data_reg_a_r[3:0]))
    else $error("group 0 not loaded on its match");

  chk_no_fire_top: assert property (
    !COMPARE_MATCH_IN[group1_trig_sel] |=> $stable(PULSE_PIN_OUT[7:4]))
    else $error("group 1 changed without its match");

  chk_layout_follows: assert property (
    (wr && hit_trig) |=>
      shared == ($past(WB_DAT_IN[1:0]) == $past(WB_DAT_IN[3:2])))
    else $error("layout does not follow the selectors");

  chk_state_pins: assert property (
    (req && !WB_WE_IN && hit_state) |=>
      WB_DAT_OUT[7:0] == $past(PULSE_PIN_OUT))
    else $error("state read does not show the pins");

  // an unmapped index must read zero so software never sees stale bits
  chk_unmapped_read: assert property (
    (req && !WB_WE_IN &&
     !(hit_low || hit_high || hit_enable || hit_trig || hit_state)) |=>
      WB_DAT_OUT == 32'h0)
    else $error("unmapped read not zero");

  cov_shared_write: cover property (wr && hit_low && shared);
  cov_split_write: cover property (wr && hit_high && !shared);
  cov_layout_change: cover property ($changed(shared));
  cov_transfer: cover property (
    COMPARE_MATCH_IN[group0_trig_sel] && |next_out_enable_reg_a_r[3:0]);
  cov_split_fire: cover property (
    !shared && COMPARE_MATCH_IN[group1_trig_sel]);

endmodule

// ===== pulse_output_next_data_a_tb.sv
// testbench for the next-output data registers of pulse groups 0 and 1.
// assumes next_data_pkg and next_data_regs are compiled before this file.
`timescale 1ns/10ps
module pulse_output_next_data_a_tb;
  localparam logic [15:0] LOW  = next_data_pkg::IDX_DATA_LOW;
  localparam logic [15:0] HIGH = next_data_pkg::IDX_DATA_HIGH;
  localparam logic [15:0] ENA  = next_data_pkg::IDX_ENABLE;
  localparam logic [15:0] TRIG = next_data_pkg::IDX_TRIG_SEL;
  localparam logic [15:0] STAT = next_data_pkg::IDX_STATE;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [17:0] adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  match = '0;
  logic [7:0]  pins;
  logic [7:0]  pins_oe;
  logic [31:0] rd;
  logic [7:0]  pin_exp;
  logic [7:0]  data;
  logic [7:0]  en;
  int          fails = 0;
  int          n_compared = 0;

  next_data_regs u_next_data_regs (
    .CLK_IN           (clk),
    .RST_IN           (rst),
    .WB_CYC_IN        (cyc),
    .WB_STB_IN        (stb),
    .WB_WE_IN         (we),
    .WB_ADR_IN        (adr),
    .WB_SEL_IN        (sel),
    .WB_DAT_IN        (wdat),
    .WB_DAT_OUT       (rdat),
    .WB_ACK_OUT       (ack),
    .COMPARE_MATCH_IN (match),
    .PULSE_PIN_OUT    (pins),
    .PULSE_PIN_OE_OUT (pins_oe)
  );

  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; the master waits for ack under a bounded count
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    check({31'h0, ack}, 32'h1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00, 4'h1);
    check(rd, exp);
  endtask

  // pins are compared one cycle after the edge that takes the match
  task automatic pulse(input int ch);
    @(posedge clk);
    match <= 4'(1 << ch);
    @(posedge clk);
    match <= 4'h0;
    @(posedge clk);
    check({24'h0, pins}, {24'h0, pin_exp});
  endtask

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("[ERR] %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    pin_exp = 8'h00;
    rd_chk(LOW, 32'h00);
    rd_chk(HIGH, 32'hff);
    rd_chk(STAT, 32'h100);
    wr(LOW, 8'ha5);
    rd_chk(LOW, 32'ha5);
    wr(HIGH, 8'h12);
    rd_chk(HIGH, 32'hff);
    rd_chk(LOW, 32'ha5);
    bus(1'b1, LOW, 8'h3c, 4'h0);
    rd_chk(LOW, 32'ha5);
    rd_chk(16'h0001, 32'h0);
    $display("test shared layout done");
    en = 8'h3c;
    wr(ENA, en);
    for (int ch = 0; ch < 4; ch++) begin
      data = 8'h5a + 8'(ch * 8'h31);
      wr(TRIG, {2'(ch), 2'(ch), 4'h0} >> 4);
      wr(LOW, data);
      check({24'h0, pins_oe}, {24'h0, en});
      pulse((ch + 1) % 4);
      pin_exp = (pin_exp & ~en) | (data & en);
      pulse(ch);
      rd_chk(STAT, {23'h0, 1'b1, pin_exp});
    end
    $display("test trigger select done");
    wr(TRIG, 8'h09);
    rd_chk(STAT, {23'h0, 1'b0, pin_exp});
    rd_chk(LOW, {24'h0, data[7:4], 4'hf});
    rd_chk(HIGH, {24'h0, 4'hf, data[3:0]});
    wr(HIGH, 8'hc3);
    data = {data[7:4], 4'h3};
    rd_chk(HIGH, 32'hf3);
    wr(LOW, 8'h73);
    data = {4'h7, data[3:0]};
    rd_chk(LOW, 32'h7f);
    wr(ENA, 8'hff);
    pulse(0);
    pin_exp[7:4] = data[7:4];
    pulse(2);
    pin_exp[3:0] = data[3:0];
    pulse(1);
    pulse(3);
    $display("test split layout done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    check({24'h0, pins}, 32'h0);
    rd_chk(LOW, 32'h00);
    rd_chk(HIGH, 32'hff);
    $display("test second reset done");
    give_verdict();
  end
endmodule
